// ===== verilog/bmt_regs.svh
// Register offsets, field positions, reset values and timing counts of the battery monitor.
// What this block does
// - Pre-low-power search starts at range code 11.
// - Step 000 moves down to next range.
// - No non-zero step found writes 00 000.
// - Writing trigger bit one reruns the search.
// - Range code reports the ten-percent band.
// - Step code reports position within band.
// - Trigger bit always reads back zero.
// - Bit 7 zero enables input-sag guard.
// - Threshold is 4.2 V plus 100 mV/code.
// - Half-speed bit halves timer outside CC/CV.
// - Limit codes 30 min, 3 h, 9 h, off.
// - Sag and timer register resets to 0x42.
// - Defaults hold until the host writes.
`ifndef BMT_REGS_SVH
`define BMT_REGS_SVH

`define BMT_ADDR_MONITOR      8'h0A
`define BMT_ADDR_SAG_TIMER    8'h0B

`define BMT_MON_TRIGGER_BIT   7
`define BMT_MON_RANGE_HI      6
`define BMT_MON_RANGE_LO      5
`define BMT_MON_STEP_HI       4
`define BMT_MON_STEP_LO       2

`define BMT_SAG_OFF_BIT       7
`define BMT_SAG_CODE_HI       6
`define BMT_SAG_CODE_LO       4
`define BMT_HALF_BIT          3
`define BMT_LIMIT_HI          2
`define BMT_LIMIT_LO          1

`define BMT_SAG_TIMER_RESET   8'h42
`define BMT_RANGE_TOP         2'h3
`define BMT_RANGE_BOTTOM      2'h0
`define BMT_STEP_NONE         3'h0

`define BMT_SAG_BASE_MV       13'h1068
`define BMT_SAG_LSB_MV        13'h0064

`define BMT_LIMIT_30MIN       2'h0
`define BMT_LIMIT_3H          2'h1
`define BMT_LIMIT_9H          2'h2
`define BMT_LIMIT_OFF         2'h3
`define BMT_MIN_30MIN         10'h01E
`define BMT_MIN_3H            10'h0B4
`define BMT_MIN_9H            10'h21C

`define BMT_SETTLE_NS         20
`define BMT_CLK_PERIOD_NS     10
`define BMT_SETTLE_CYC        ((`BMT_SETTLE_NS + `BMT_CLK_PERIOD_NS - 1) / `BMT_CLK_PERIOD_NS)

`endif

// ===== verilog/bmt_pkg.sv
// Types shared by the battery monitor and timer register logic.
package bmt_pkg;

  typedef enum logic [2:0] {
    SRCH_IDLE   = 3'b001,
    SRCH_SETTLE = 3'b010,
    SRCH_CHECK  = 3'b100
  } bmt_search_state_type;

  typedef logic [1:0] bmt_range_type;
  typedef logic [2:0] bmt_step_type;

endpackage

// ===== verilog/bmt_search.sv
// Range and step search of the voltage based battery monitor.
`timescale 1ns/1ps
`default_nettype none
`include "bmt_regs.svh"

module bmt_search (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             startPulse,
  input  wire bmt_pkg::bmt_step_type stepIn,
  output logic                  busy,
  output bmt_pkg::bmt_range_type probeRange,
  output logic                  donePulse,
  output bmt_pkg::bmt_range_type resultRange,
  output bmt_pkg::bmt_step_type resultStep
);
  import bmt_pkg::*;

  localparam logic [3:0] SETTLE_LAST = 4'(`BMT_SETTLE_CYC - 1);

  bmt_search_state_type stateFf;
  bmt_search_state_type nxt_state;
  bmt_range_type        rangeFf;
  bmt_range_type        nxt_range;
  logic [3:0]           settleFf;
  logic                 doneFf;
  bmt_range_type        resRangeFf;
  bmt_step_type         resStepFf;

  wire stepFound  = (stepIn != `BMT_STEP_NONE);
  wire atBottom   = (rangeFf == `BMT_RANGE_BOTTOM);
  wire settleDone = (settleFf == SETTLE_LAST);
  wire finish     = (stateFf == SRCH_CHECK) && (stepFound || atBottom);

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    nxt_state = stateFf;
    nxt_range = rangeFf;
    case (stateFf)
      SRCH_IDLE: begin
        if (startPulse) begin
          nxt_state = SRCH_SETTLE;
          nxt_range = `BMT_RANGE_TOP;
        end
      end
      SRCH_SETTLE: begin
        if (settleDone) begin
          nxt_state = SRCH_CHECK;
        end
      end
      SRCH_CHECK: begin
        if (finish) begin
          nxt_state = SRCH_IDLE;
        end else begin
          nxt_state = SRCH_SETTLE;
          nxt_range = rangeFf - 2'h1;
        end
      end
      default: begin
        nxt_state = SRCH_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State, settle counter and held result.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateFf  <= SRCH_IDLE;
      rangeFf  <= `BMT_RANGE_TOP;
      settleFf <= 4'h0;
    end else begin
      stateFf  <= nxt_state;
      rangeFf  <= nxt_range;
      settleFf <= (stateFf == SRCH_SETTLE && !settleDone) ? settleFf + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      doneFf     <= 1'b0;
      resRangeFf <= `BMT_RANGE_BOTTOM;
      resStepFf  <= `BMT_STEP_NONE;
    end else begin
      doneFf <= finish;
      if (finish) begin
        // A bottom range with step 000 leaves 00 000, matching the no-find case.
        resRangeFf <= rangeFf;
        resStepFf  <= stepIn;
      end
    end
  end

  assign busy        = (stateFf != SRCH_IDLE);
  assign probeRange  = rangeFf;
  assign donePulse   = doneFf;
  assign resultRange = resRangeFf;
  assign resultStep  = resStepFf;

endmodule
`default_nettype wire

// ===== verilog/bmt_top.sv
// Battery monitor register and input-sag/safety-timer control register.
`timescale 1ns/1ps
`default_nettype none
`include "bmt_regs.svh"

module bmt_top (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  output logic [7:0]                 regRdData,
  input  wire logic                  lowPowerEntry,
  input  wire bmt_pkg::bmt_step_type stepIn,
  output bmt_pkg::bmt_range_type     probeRange,
  output logic                       searchBusy,
  output logic                       searchDone,
  input  wire logic                  timerTickIn,
  input  wire logic                  ccOrCvActive,
  output logic                       safetyTick,
  output logic                       inputSagGuardEn,
  output logic [12:0]                inputSagThresholdMv,
  output logic [1:0]                 safetyLimitSelect,
  output logic [9:0]                 safetyLimitMinutes,
  output logic                       safetyTimerOff
);
  import bmt_pkg::*;

  // ****************************************************************
  // Register decode.
  // ****************************************************************
  logic [7:0]   sagTimerFf;
  logic [7:0]   rdDataFf;
  logic         probeBusyFf;
  logic         doneOutFf;
  bmt_range_type probeRangeFf;
  logic         halfPhaseFf;
  logic         safetyTickFf;
  logic         guardEnFf;
  logic [12:0]  sagMvFf;
  logic [1:0]   limitSelFf;
  logic [9:0]   limitMinFf;
  logic         timerOffFf;

  wire           srchBusy;
  wire           srchDone;
  bmt_range_type srchProbe;
  bmt_range_type resRange;
  bmt_step_type  resStep;

  wire hitMonitor  = (regAddr == `BMT_ADDR_MONITOR);
  wire hitSagTimer = (regAddr == `BMT_ADDR_SAG_TIMER);
  wire trigWrite   = regWrEn && hitMonitor && regWrData[`BMT_MON_TRIGGER_BIT];
  wire startSearch = (trigWrite || lowPowerEntry) && !srchBusy;

  // Trigger bit reads 0; the low two bits are unused and read 0.
  wire [7:0] monitorView = {1'b0, resRange, resStep, 2'b00};
  wire [7:0] rdMux = hitMonitor  ? monitorView :
                     hitSagTimer ? sagTimerFf  : 8'h00;

  wire [2:0]  sagCode   = sagTimerFf[`BMT_SAG_CODE_HI:`BMT_SAG_CODE_LO];
  wire [12:0] sagMv     = `BMT_SAG_BASE_MV + 13'(sagCode) * `BMT_SAG_LSB_MV;
  wire        halfEn    = sagTimerFf[`BMT_HALF_BIT];
  wire [1:0]  limitCode = sagTimerFf[`BMT_LIMIT_HI:`BMT_LIMIT_LO];
  wire        halfSlow  = halfEn && !ccOrCvActive;
  wire        tickPass  = timerTickIn && (!halfSlow || halfPhaseFf);
  wire [9:0]  limitMin  = (limitCode == `BMT_LIMIT_30MIN) ? `BMT_MIN_30MIN :
                          (limitCode == `BMT_LIMIT_3H)    ? `BMT_MIN_3H    :
                          (limitCode == `BMT_LIMIT_9H)    ? `BMT_MIN_9H    : 10'h000;

  bmt_search u_search (
    .clk         (clk),
    .rstn        (rstn),
    .startPulse  (startSearch),
    .stepIn      (stepIn),
    .busy        (srchBusy),
    .probeRange  (srchProbe),
    .donePulse   (srchDone),
    .resultRange (resRange),
    .resultStep  (resStep)
  );

  // ****************************************************************
  // Writable register and read data.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sagTimerFf <= `BMT_SAG_TIMER_RESET;
    end else if (regWrEn && hitSagTimer) begin
      sagTimerFf <= {regWrData[7:1], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdDataFf <= 8'h00;
    end else if (regRdEn) begin
      rdDataFf <= rdMux;
    end
  end

  // ****************************************************************
  // Search status to the pins.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      probeBusyFf  <= 1'b0;
      doneOutFf    <= 1'b0;
      probeRangeFf <= `BMT_RANGE_TOP;
    end else begin
      probeBusyFf  <= srchBusy;
      doneOutFf    <= srchDone;
      probeRangeFf <= srchProbe;
    end
  end

  // ****************************************************************
  // Input-sag guard and safety timer controls.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halfPhaseFf  <= 1'b0;
      safetyTickFf <= 1'b0;
    end else begin
      safetyTickFf <= tickPass;
      if (timerTickIn && halfSlow) begin
        halfPhaseFf <= !halfPhaseFf;
      end else if (!halfSlow) begin
        halfPhaseFf <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      guardEnFf  <= 1'b0;
      sagMvFf    <= 13'h0000;
      limitSelFf <= 2'h0;
      limitMinFf <= 10'h000;
      timerOffFf <= 1'b0;
    end else begin
      guardEnFf  <= !sagTimerFf[`BMT_SAG_OFF_BIT];
      sagMvFf    <= sagMv;
      limitSelFf <= limitCode;
      limitMinFf <= limitMin;
      timerOffFf <= (limitCode == `BMT_LIMIT_OFF);
    end
  end

  assign regRdData           = rdDataFf;
  assign probeRange          = probeRangeFf;
  assign searchBusy          = probeBusyFf;
  assign searchDone          = doneOutFf;
  assign safetyTick          = safetyTickFf;
  assign inputSagGuardEn     = guardEnFf;
  assign inputSagThresholdMv = sagMvFf;
  assign safetyLimitSelect   = limitSelFf;
  assign safetyLimitMinutes  = limitMinFf;
  assign safetyTimerOff      = timerOffFf;

endmodule
`default_nettype wire

// ===== dv/bmt_top_sva.sv
// Concurrent checks on the ports of the battery monitor and sag/timer register block.
`timescale 1ns/1ps
`default_nettype none
module bmt_top_sva (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  regWrEn,
  input wire logic                  regRdEn,
  input wire logic [7:0]            regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic [7:0]            regRdData,
  input wire bmt_pkg::bmt_range_type probeRange,
  input wire logic                  searchBusy,
  input wire logic                  searchDone,
  input wire logic                  timerTickIn,
  input wire logic                  ccOrCvActive,
  input wire logic                  safetyTick,
  input wire logic                  inputSagGuardEn,
  input wire logic [12:0]           inputSagThresholdMv,
  input wire logic [1:0]            safetyLimitSelect,
  input wire logic [9:0]            safetyLimitMinutes,
  input wire logic                  safetyTimerOff
);
  import bmt_pkg::*;
  wire sagWr = regWrEn && regAddr == 8'h0B;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_trig_reads_zero: assert property (regRdEn && regAddr == 8'h0A |=> !regRdData[7])
    else $error("trigger bit read back as one");
  a_guard_follows_bit: assert property (sagWr |-> ##2 inputSagGuardEn == !$past(regWrData[7], 2))
    else $error("sag guard enable does not follow bit 7");
  a_sag_threshold: assert property (sagWr |-> ##2 inputSagThresholdMv ==
    13'h1068 + 13'($past(regWrData[6:4], 2)) * 13'h0064) else $error("sag threshold wrong");
  a_limit_copy: assert property (sagWr |-> ##2 safetyLimitSelect == $past(regWrData[2:1], 2))
    else $error("limit select does not follow write");
  a_limit_minutes: assert property ($past(rstn) |-> safetyLimitMinutes ==
    (safetyLimitSelect == 2'h0 ? 10'h01E : safetyLimitSelect == 2'h1 ? 10'h0B4 :
     safetyLimitSelect == 2'h2 ? 10'h21C : 10'h000)) else $error("limit minutes wrong");
  a_timer_off: assert property ($past(rstn) |-> safetyTimerOff == (safetyLimitSelect == 2'h3))
    else $error("timer off flag wrong");
  a_tick_source: assert property (!timerTickIn |=> !safetyTick)
    else $error("safety tick without input tick");
  a_tick_full_rate: assert property (timerTickIn && ccOrCvActive |=> safetyTick)
    else $error("tick dropped in constant current or voltage");
  a_probe_top: assert property ($rose(searchBusy) |-> probeRange == 2'h3)
    else $error("search did not start at top range");
  a_probe_down: assert property (searchBusy && $past(searchBusy) && $changed(probeRange)
    |-> probeRange == $past(probeRange) - 2'h1) else $error("range did not step down by one");
  a_done_bound: assert property ($rose(searchBusy) |-> ##[1:14] searchDone)
    else $error("search did not complete in time");
  c_search: cover property (searchDone);
  c_tick: cover property (safetyTick);
  c_sag_write: cover property (sagWr);
endmodule
bind bmt_top bmt_top_sva u_bmt_top_sva (.clk(clk), .rstn(rstn), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .probeRange(probeRange), .searchBusy(searchBusy), .searchDone(searchDone),
  .timerTickIn(timerTickIn), .ccOrCvActive(ccOrCvActive), .safetyTick(safetyTick),
  .inputSagGuardEn(inputSagGuardEn), .inputSagThresholdMv(inputSagThresholdMv),
  .safetyLimitSelect(safetyLimitSelect), .safetyLimitMinutes(safetyLimitMinutes),
  .safetyTimerOff(safetyTimerOff));
`default_nettype wire

// ===== dv/bmt_cell_model.sv
// Behavioural model of the analog comparator bank answering range probes.
`timescale 1ns/1ps
`default_nettype none
module bmt_cell_model (
  input  wire logic                   clk,
  input  wire bmt_pkg::bmt_range_type probeRange,
  input  wire bmt_pkg::bmt_range_type tgtRange,
  input  wire bmt_pkg::bmt_step_type  tgtStep,
  output bmt_pkg::bmt_step_type       stepIn
);
  import bmt_pkg::*;
  // Only the band holding the battery level reports a step; other bands read zero.
  always_ff @(posedge clk) begin
    stepIn <= (probeRange == tgtRange) ? tgtStep : 3'h0;
  end
endmodule
`default_nettype wire

// ===== dv/test_battery_monitor_and_timer_regs.sv
// Self-checking testbench for the battery monitor and sag/timer registers.
`timescale 1ns/1ps
`default_nettype none
module test_battery_monitor_and_timer_regs;
  import bmt_pkg::*;
  logic clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, lowPowerEntry = 0, rdPend = 0;
  logic timerTickIn = 0, ccOrCvActive = 0, searchBusy, searchDone, safetyTick;
  logic inputSagGuardEn, safetyTimerOff;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [12:0] inputSagThresholdMv;
  logic [1:0] safetyLimitSelect;
  logic [9:0] safetyLimitMinutes;
  bmt_step_type stepIn, tgtStep = 3'h0;
  bmt_range_type probeRange, tgtRange = 2'h0;
  bmt_step_type codes[5] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1};
  logic [7:0] expQ[$];
  int n_mismatch = 0, total_checks = 0, cycles = 0, ticks = 0;
  integer seed = 32'h65CD5C96;
  bmt_top u_bmt_top (.clk(clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .lowPowerEntry(lowPowerEntry), .stepIn(stepIn), .probeRange(probeRange),
    .searchBusy(searchBusy), .searchDone(searchDone), .timerTickIn(timerTickIn),
    .ccOrCvActive(ccOrCvActive), .safetyTick(safetyTick), .inputSagGuardEn(inputSagGuardEn),
    .inputSagThresholdMv(inputSagThresholdMv), .safetyLimitSelect(safetyLimitSelect),
    .safetyLimitMinutes(safetyLimitMinutes), .safetyTimerOff(safetyTimerOff));
  bmt_cell_model u_bmt_cell_model (.clk(clk), .probeRange(probeRange), .tgtRange(tgtRange),
    .tgtStep(tgtStep), .stepIn(stepIn));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    rdPend <= regRdEn;
    if (safetyTick === 1'b1) ticks++;
    if (cycles == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Read data is registered, so it is compared one cycle after the strobe.
  always @(negedge clk) begin
    if (rdPend) check("regRdData", regRdData, expQ.pop_front());
  end
  // Decoded controls must show the reset value of the sag/timer register.
  task automatic defaults();
    check("inputSagGuardEn", inputSagGuardEn, 13'h0001);
    check("inputSagThresholdMv", inputSagThresholdMv, 13'h11F8);
    check("safetyLimitSelect", safetyLimitSelect, 13'h0001);
    check("safetyLimitMinutes", safetyLimitMinutes, 13'h00B4);
    check("safetyTimerOff", safetyTimerOff, 13'h0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); regWrEn = 1; regAddr = a; regWrData = d;
    @(negedge clk); regWrEn = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk); regRdEn = 1; regAddr = a; expQ.push_back(e);
    @(negedge clk); regRdEn = 0;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk); timerTickIn = 1;
      @(negedge clk); timerTickIn = 0;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic search(input bmt_range_type r, input bmt_step_type s, input logic viaReg);
    int n;
    tgtRange = r;
    tgtStep = s;
    if (viaReg) wr(8'h0A, 8'h80);
    else begin
      @(negedge clk); lowPowerEntry = 1;
      @(negedge clk); lowPowerEntry = 0;
    end
    n = 0;
    while (searchDone !== 1'b1 && n < 40) begin
      @(negedge clk); n++;
    end
    check("searchDone", searchDone, 1'b1);
    rd(8'h0A, (s == 3'h0) ? 8'h00 : {1'b0, r, s, 2'h0});
  endtask
  initial begin
    logic [7:0] d;
    repeat (16) @(negedge clk);
    rstn = 1;
    rd(8'h0B, 8'h42);
    rd(8'h0A, 8'h00);
    defaults();
    for (int i = 0; i < 9; i++) search(2'(i), (i == 8) ? 3'h0 : codes[i % 5], i[0]);
    search(2'h2, 3'h3, 1'b0);
    wr(8'h0A, 8'h7F);
    rd(8'h0A, 8'h4C);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wr(8'h0B, d);
      rd(8'h0B, d & 8'hFE);
      check("inputSagGuardEn", inputSagGuardEn, 13'(!d[7]));
      check("inputSagThresholdMv", inputSagThresholdMv, 13'h1068 + 13'(d[6:4]) * 13'h0064);
      check("safetyLimitSelect", safetyLimitSelect, 13'(d[2:1]));
      check("safetyTimerOff", safetyTimerOff, 13'(d[2:1] == 2'h3));
    end
    wr(8'h0B, 8'h08);
    ticks = 0;
    pulse(4);
    check("safetyTick", 13'(ticks), 13'h0002);
    ccOrCvActive = 1;
    ticks = 0;
    pulse(4);
    check("safetyTick", 13'(ticks), 13'h0004);
    ccOrCvActive = 0;
    wr(8'h0B, 8'h00);
    ticks = 0;
    pulse(4);
    check("safetyTick", 13'(ticks), 13'h0004);
    // A reset in mid-run must bring back the defaults and clear the held result.
    @(negedge clk);
    rstn = 0;
    repeat (3) @(negedge clk);
    rstn = 1;
    rd(8'h0B, 8'h42);
    rd(8'h0A, 8'h00);
    defaults();
    conclude();
  end
endmodule
`default_nettype wire
